// ===== include/cpx_pkg.sv
// Constants, instruction layout and state codes for the character processor.
// Assumes a 32-bit word memory with four 8-bit characters per word.
//
// Overview of operation
// - Masked load copies memory bits only where mask register E holds ones.
// - Masked store changes memory bits only where mask register E holds ones; with X=1 the other bits take low W/C bits.
// - Group loads put word characters C1..C4 into A..D or E..H.
// - Group stores put A..D or E..H into word characters C1..C4.
// - Pair loads put low 16 word bits into A:C or B:D.
// - Pair stores put A:C or B:D into the low word half.
// - Add and subtract are unsigned 8-bit; carry or borrow sets overflow memo.
// - Compare: greater runs next, equal skips one, less skips two.
// - Xor replaces memory character with character xor register; register unchanged.
// - Set bits forces mask-selected register bits to the polarity value.
// - Bit test skips on all-match with I=1 or any-mismatch with I=0.
// - Parity test skips on odd parity with I=1, even with I=0.
// - Shift count from low instruction bits, indexable, at most 8.
// - Open left shift drops high bits and fills zeros from below.
// - Cyclic left rotate feeds high-order bits back into the low end.
// - Jump continues at the indexed and indirect effective word address.
// - Jump-and-link stores own address plus one in target word address field.
// - Halt clears running; program start resumes at the program counter.
// - Index ops: X picks register, R literal or register step, I tests.
// - Index decrement jumps to W unless it reached or passed zero, when tested.
// - Index increment runs next if above W/C or overflowed, else skips when tested.
// - X equal to one takes operand from low W/C bits; masked store and xor still read the memory word.
// - W/C all zero with X other than one takes operand two from the register numbered by X.
// - R field selects one of eight data registers A through H.

package cpx_pkg;

  typedef struct packed {
    logic [5:0]  op;
    logic        u;
    logic [2:0]  r;
    logic        i;
    logic [2:0]  x;
    logic [15:0] w;
    logic [1:0]  c;
  } cpx_instr_t;

  typedef logic [3:0][7:0] cpx_word_t;
  typedef logic [7:0][7:0] cpx_regs_t;

  localparam logic [5:0] OP_NOP                = 6'h00;
  localparam logic [5:0] OP_CHAR_LOAD          = 6'h01;
  localparam logic [5:0] OP_MASKED_CHAR_LOAD   = 6'h02;
  localparam logic [5:0] OP_CHAR_STORE         = 6'h03;
  localparam logic [5:0] OP_MASKED_CHAR_STORE  = 6'h04;
  localparam logic [5:0] OP_LOW_GROUP_LOAD     = 6'h05;
  localparam logic [5:0] OP_HIGH_GROUP_LOAD    = 6'h06;
  localparam logic [5:0] OP_LOW_GROUP_STORE    = 6'h07;
  localparam logic [5:0] OP_HIGH_GROUP_STORE   = 6'h08;
  localparam logic [5:0] OP_INDEX_PAIR2_LOAD   = 6'h09;
  localparam logic [5:0] OP_INDEX_PAIR3_LOAD   = 6'h0a;
  localparam logic [5:0] OP_INDEX_PAIR2_STORE  = 6'h0b;
  localparam logic [5:0] OP_INDEX_PAIR3_STORE  = 6'h0c;
  localparam logic [5:0] OP_ADD                = 6'h0d;
  localparam logic [5:0] OP_SUB                = 6'h0e;
  localparam logic [5:0] OP_CHAR_COMPARE       = 6'h0f;
  localparam logic [5:0] OP_XOR_INTO_MEMORY    = 6'h10;
  localparam logic [5:0] OP_SET_BITS           = 6'h11;
  localparam logic [5:0] OP_BIT_TEST           = 6'h12;
  localparam logic [5:0] OP_PARITY_TEST        = 6'h13;
  localparam logic [5:0] OP_SHIFT_LEFT         = 6'h14;
  localparam logic [5:0] OP_CYCLIC_LEFT_ROTATE = 6'h15;
  localparam logic [5:0] OP_JUMP               = 6'h16;
  localparam logic [5:0] OP_JUMP_AND_LINK      = 6'h17;
  localparam logic [5:0] OP_HALT_INSTR         = 6'h18;
  localparam logic [5:0] OP_INDEX_DECREMENT    = 6'h19;
  localparam logic [5:0] OP_INDEX_INCREMENT    = 6'h1a;

  // X field codes
  localparam logic [2:0] X_NONE   = 3'h0;
  localparam logic [2:0] X_DIRECT = 3'h1;
  localparam logic [2:0] X_PAIR2  = 3'h2;
  localparam logic [2:0] X_PAIR3  = 3'h3;

  // Data register numbers
  localparam logic [2:0] REG_A = 3'h0;
  localparam logic [2:0] REG_B = 3'h1;
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_D = 3'h3;
  localparam logic [2:0] REG_E = 3'h4;

  localparam logic [3:0]  MAX_SHIFT   = 4'h8;
  localparam logic [3:0]  BE_ONE      = 4'h1;
  localparam logic [3:0]  BE_ALL      = 4'hf;
  localparam logic [3:0]  BE_LOW_HALF = 4'h3;
  localparam logic [15:0] PC_STEP     = 16'h0001;
  localparam logic [15:0] PC_RESET    = 16'h0000;

  // ALU functions
  localparam logic [2:0] FN_ADD    = 3'h0;
  localparam logic [2:0] FN_SUB    = 3'h1;
  localparam logic [2:0] FN_XOR    = 3'h2;
  localparam logic [2:0] FN_SET    = 3'h3;
  localparam logic [2:0] FN_SHL    = 3'h4;
  localparam logic [2:0] FN_ROL    = 3'h5;
  localparam logic [2:0] FN_TEST   = 3'h6;
  localparam logic [2:0] FN_PARITY = 3'h7;

  typedef enum logic [6:0] {
    ST_HALT  = 7'h01,
    ST_FETCH = 7'h02,
    ST_FWAIT = 7'h04,
    ST_ADDR  = 7'h08,
    ST_IWAIT = 7'h10,
    ST_OWAIT = 7'h20,
    ST_EXEC  = 7'h40
  } cpx_state_t;

endpackage

// ===== include/cpx_alu_if.sv
// Interface between the sequencer and the character ALU.
// Assumes both ends sit in one clock domain; the ALU is purely combinational.
`timescale 1ns/1ns
`default_nettype none

interface cpx_alu_if;
  logic [2:0] fn;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] mask;
  logic       pol;
  logic       ind;
  logic [3:0] shamt;
  logic [7:0] res;
  logic       carry;
  logic       gt;
  logic       eq;
  logic       hit;

  modport ctl (output fn, a, b, mask, pol, ind, shamt, input res, carry, gt, eq, hit);
  modport alu (input fn, a, b, mask, pol, ind, shamt, output res, carry, gt, eq, hit);
endinterface

`default_nettype wire

// ===== logic/cpx_alu.sv
// Character ALU: arithmetic, logic, shifts and bit tests on one 8-bit character.
// Assumes operands are stable for the cycle; no state is kept here.
`timescale 1ns/1ns
`default_nettype none

module cpx_alu (
  cpx_alu_if.alu bus
);

  logic [8:0]  sum9;
  logic [8:0]  diff9;
  logic [7:0]  sel;
  logic [15:0] rot16;
  logic        match;

  always_comb begin
    sum9      = {1'b0, bus.a} + {1'b0, bus.b};
    diff9     = {1'b0, bus.a} - {1'b0, bus.b};
    sel       = bus.a & bus.mask;
    rot16     = {bus.a, bus.a} << bus.shamt;
    match     = bus.pol ? (sel == bus.mask) : (sel == 8'h00);
    bus.res   = bus.a;
    bus.carry = 1'b0;
    bus.hit   = 1'b0;
    bus.gt    = bus.a > bus.b;
    bus.eq    = bus.a == bus.b;
    case (bus.fn)
      cpx_pkg::FN_ADD: begin
        bus.res   = sum9[7:0];
        bus.carry = sum9[8];
      end
      cpx_pkg::FN_SUB: begin
        bus.res   = diff9[7:0];
        bus.carry = diff9[8];
      end
      cpx_pkg::FN_XOR: bus.res = bus.a ^ bus.b;
      cpx_pkg::FN_SET: bus.res = bus.pol ? (bus.a | bus.mask) : (bus.a & ~bus.mask);
      cpx_pkg::FN_SHL: bus.res = bus.a << bus.shamt;
      cpx_pkg::FN_ROL: bus.res = rot16[15:8];
      cpx_pkg::FN_TEST: bus.hit = bus.ind ? match : !match;
      cpx_pkg::FN_PARITY: bus.hit = bus.ind ? (^sel) : !(^sel);
      default: bus.res = bus.a;
    endcase
  end

endmodule

`default_nettype wire

// ===== logic/cpx_exec.sv
// Instruction sequencer and executor of the character processor.
// Assumes a word memory that takes a request when mem_req_o is high and
// answers reads with mem_rvalid_i at least one cycle later.
`timescale 1ns/1ns
`default_nettype none

module cpx_exec (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        start_i,
  input  wire logic        ovf_clr_i,
  input  wire logic        mem_rvalid_i,
  input  wire logic [31:0] mem_rdata_i,
  output var  logic        mem_req_o,
  output var  logic        mem_we_o,
  output var  logic [15:0] mem_addr_o,
  output var  logic [31:0] mem_wdata_o,
  output var  logic [3:0]  mem_be_o,
  output var  logic        running_o,
  output var  logic        overflow_o,
  output var  logic [15:0] pc_o,
  output var  logic [63:0] data_regs_o
);

  typedef struct packed {
    cpx_pkg::cpx_state_t st;
    logic                run;
    logic [15:0]         pc;
    cpx_pkg::cpx_instr_t ir;
    logic [17:0]         ea;
    logic                ind;
    logic [31:0]         opw;
    cpx_pkg::cpx_regs_t  regs;
    logic                ovf;
    logic                req;
    logic                we;
    logic [15:0]         addr;
    logic [31:0]         wdata;
    logic [3:0]          be;
  } cpx_core_t;

  localparam cpx_core_t CORE_RST = '{st: cpx_pkg::ST_HALT, pc: cpx_pkg::PC_RESET, default: '0};

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_b;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  cpx_core_t q;
  cpx_core_t d;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [17:0] idx_val(input cpx_pkg::cpx_regs_t rg, input logic [2:0] x);
    case (x)
      cpx_pkg::X_NONE,
      cpx_pkg::X_DIRECT: idx_val = 18'h00000;
      cpx_pkg::X_PAIR2:  idx_val = {2'b00, rg[cpx_pkg::REG_A], rg[cpx_pkg::REG_C]};
      cpx_pkg::X_PAIR3:  idx_val = {2'b00, rg[cpx_pkg::REG_B], rg[cpx_pkg::REG_D]};
      default:           idx_val = {10'h000, rg[x]};
    endcase
  endfunction

  function automatic logic [2:0] alu_fn(input logic [5:0] op);
    case (op)
      cpx_pkg::OP_ADD:                alu_fn = cpx_pkg::FN_ADD;
      cpx_pkg::OP_SUB:                alu_fn = cpx_pkg::FN_SUB;
      cpx_pkg::OP_SET_BITS:           alu_fn = cpx_pkg::FN_SET;
      cpx_pkg::OP_SHIFT_LEFT:         alu_fn = cpx_pkg::FN_SHL;
      cpx_pkg::OP_CYCLIC_LEFT_ROTATE: alu_fn = cpx_pkg::FN_ROL;
      cpx_pkg::OP_BIT_TEST:           alu_fn = cpx_pkg::FN_TEST;
      cpx_pkg::OP_PARITY_TEST:        alu_fn = cpx_pkg::FN_PARITY;
      default:                        alu_fn = cpx_pkg::FN_XOR;
    endcase
  endfunction

  cpx_pkg::cpx_instr_t instr_in;
  cpx_pkg::cpx_word_t  opw_chars;
  logic                imm;
  logic                wc_zero;
  logic                char_op;
  logic                group_op;
  logic                pair_load;
  logic                uses_addr;
  logic                needs_read;
  logic [7:0]          cur_reg;
  logic [7:0]          mask_e;
  logic [7:0]          mem_char;
  logic [7:0]          op2;
  logic [7:0]          low_wc;
  logic [3:0]          lane_be;
  logic [15:0]         pc_next1;

  assign instr_in  = cpx_pkg::cpx_instr_t'(mem_rdata_i);
  assign opw_chars = cpx_pkg::cpx_word_t'(q.opw);
  assign imm       = q.ir.x == cpx_pkg::X_DIRECT;
  assign wc_zero   = {q.ir.w, q.ir.c} == 18'h00000;
  assign low_wc    = {q.ir.w[5:0], q.ir.c};
  assign cur_reg   = q.regs[q.ir.r];
  assign mask_e    = q.regs[cpx_pkg::REG_E];
  assign mem_char  = opw_chars[~q.ea[1:0]];
  assign op2       = imm ? low_wc : (wc_zero ? q.regs[q.ir.x] : mem_char);
  assign lane_be   = cpx_pkg::BE_ONE << ~q.ea[1:0];
  assign pc_next1  = q.pc + cpx_pkg::PC_STEP;

  assign char_op   = q.ir.op inside {cpx_pkg::OP_CHAR_LOAD, cpx_pkg::OP_MASKED_CHAR_LOAD,
                                     cpx_pkg::OP_ADD, cpx_pkg::OP_SUB,
                                     cpx_pkg::OP_CHAR_COMPARE};
  assign group_op  = q.ir.op inside {cpx_pkg::OP_LOW_GROUP_LOAD, cpx_pkg::OP_HIGH_GROUP_LOAD};
  assign pair_load = q.ir.op inside {cpx_pkg::OP_INDEX_PAIR2_LOAD, cpx_pkg::OP_INDEX_PAIR3_LOAD};
  assign uses_addr = (q.ir.op inside {[cpx_pkg::OP_CHAR_LOAD:cpx_pkg::OP_XOR_INTO_MEMORY],
                                      cpx_pkg::OP_JUMP, cpx_pkg::OP_JUMP_AND_LINK})
                     && !imm && !wc_zero;
  assign needs_read = (char_op && !imm && !wc_zero) || group_op || (pair_load && !imm)
                      || (q.ir.op inside {cpx_pkg::OP_MASKED_CHAR_STORE,
                                          cpx_pkg::OP_XOR_INTO_MEMORY} && !wc_zero)
                      || q.ir.op == cpx_pkg::OP_JUMP_AND_LINK;

  // ---------------------------------------------------------------
  // Character ALU
  // ---------------------------------------------------------------
  cpx_alu_if alu_bus ();

  cpx_alu u_alu (
    .bus (alu_bus.alu)
  );

  assign alu_bus.fn   = alu_fn(q.ir.op);
  assign alu_bus.a    = cur_reg;
  assign alu_bus.b    = op2;
  assign alu_bus.mask = low_wc;
  assign alu_bus.pol  = q.ir.u;
  assign alu_bus.ind  = q.ir.i;
  assign alu_bus.shamt = (q.ea > {14'h0000, cpx_pkg::MAX_SHIFT}) ? cpx_pkg::MAX_SHIFT
                                                                  : q.ea[3:0];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0]          skip;
    logic                jumped;
    logic [7:0]          cval;
    logic [15:0]         step;
    logic [15:0]         ix;
    logic [16:0]         ires;
    logic                wide;
    logic                iovf;
    cpx_pkg::cpx_instr_t lw;
    d      = q;
    skip   = 2'b00;
    jumped = 1'b0;
    cval   = 8'h00;
    wide   = q.ir.x inside {cpx_pkg::X_PAIR2, cpx_pkg::X_PAIR3};
    ix     = 16'(idx_val(q.regs, q.ir.x));
    step   = q.ir.u ? {8'h00, q.regs[q.ir.r]} : {13'h0000, q.ir.r};
    ires   = 17'h00000;
    iovf   = 1'b0;
    lw     = cpx_pkg::cpx_instr_t'(q.opw);
    d.req  = 1'b0;
    d.we   = 1'b0;
    if (ovf_clr_i) begin
      d.ovf = 1'b0;
    end
    case (q.st)
      cpx_pkg::ST_HALT: begin
        if (start_i) begin
          d.run = 1'b1;
          d.st  = cpx_pkg::ST_FETCH;
        end
      end
      cpx_pkg::ST_FETCH: begin
        d.req  = 1'b1;
        d.be   = cpx_pkg::BE_ALL;
        d.addr = q.pc;
        d.st   = cpx_pkg::ST_FWAIT;
      end
      cpx_pkg::ST_FWAIT: begin
        if (mem_rvalid_i) begin
          d.ir  = instr_in;
          d.ea  = {instr_in.w, instr_in.c} + idx_val(q.regs, instr_in.x);
          d.ind = instr_in.i;
          d.st  = cpx_pkg::ST_ADDR;
        end
      end
      cpx_pkg::ST_ADDR: begin
        d.be   = cpx_pkg::BE_ALL;
        d.addr = q.ea[17:2];
        if (uses_addr && q.ind) begin
          d.req = 1'b1;
          d.st  = cpx_pkg::ST_IWAIT;
        end else if (needs_read) begin
          d.req = 1'b1;
          d.st  = cpx_pkg::ST_OWAIT;
        end else begin
          d.st = cpx_pkg::ST_EXEC;
        end
      end
      // Each indirect level brings its own I and X
      cpx_pkg::ST_IWAIT: begin
        if (mem_rvalid_i) begin
          d.ea  = {instr_in.w, instr_in.c} + idx_val(q.regs, instr_in.x);
          d.ind = instr_in.i;
          d.st  = cpx_pkg::ST_ADDR;
        end
      end
      cpx_pkg::ST_OWAIT: begin
        if (mem_rvalid_i) begin
          d.opw = mem_rdata_i;
          d.st  = cpx_pkg::ST_EXEC;
        end
      end
      cpx_pkg::ST_EXEC: begin
        d.st    = cpx_pkg::ST_FETCH;
        d.addr  = q.ea[17:2];
        d.wdata = {4{cur_reg}};
        d.be    = lane_be;
        case (q.ir.op)
          cpx_pkg::OP_CHAR_LOAD: d.regs[q.ir.r] = op2;
          cpx_pkg::OP_MASKED_CHAR_LOAD: d.regs[q.ir.r] = (cur_reg & ~mask_e) | (op2 & mask_e);
          cpx_pkg::OP_CHAR_STORE,
          cpx_pkg::OP_MASKED_CHAR_STORE,
          cpx_pkg::OP_XOR_INTO_MEMORY: begin
            cval = cur_reg;
            if (q.ir.op == cpx_pkg::OP_MASKED_CHAR_STORE) begin
              cval = (op2 & ~mask_e) | (cur_reg & mask_e);
            end
            if (q.ir.op == cpx_pkg::OP_XOR_INTO_MEMORY) begin
              cval = alu_bus.res;
            end
            if (wc_zero) begin
              d.regs[q.ir.x] = cval;
            end else begin
              d.req   = 1'b1;
              d.we    = 1'b1;
              d.wdata = {4{cval}};
            end
          end
          cpx_pkg::OP_LOW_GROUP_LOAD,
          cpx_pkg::OP_HIGH_GROUP_LOAD: begin
            for (int k = 0; k < 4; k++) begin
              d.regs[{q.ir.op == cpx_pkg::OP_HIGH_GROUP_LOAD, 2'(k)}] = opw_chars[2'(3 - k)];
            end
          end
          cpx_pkg::OP_LOW_GROUP_STORE,
          cpx_pkg::OP_HIGH_GROUP_STORE: begin
            d.req   = 1'b1;
            d.we    = 1'b1;
            d.be    = cpx_pkg::BE_ALL;
            d.wdata = (q.ir.op == cpx_pkg::OP_LOW_GROUP_STORE) ? q.regs[3:0] : q.regs[7:4];
            d.wdata = {d.wdata[7:0], d.wdata[15:8], d.wdata[23:16], d.wdata[31:24]};
          end
          cpx_pkg::OP_INDEX_PAIR2_LOAD,
          cpx_pkg::OP_INDEX_PAIR3_LOAD: begin
            ix = imm ? {q.ir.w[13:0], q.ir.c} : q.opw[15:0];
            if (q.ir.op == cpx_pkg::OP_INDEX_PAIR2_LOAD) begin
              d.regs[cpx_pkg::REG_A] = ix[15:8];
              d.regs[cpx_pkg::REG_C] = ix[7:0];
            end else begin
              d.regs[cpx_pkg::REG_B] = ix[15:8];
              d.regs[cpx_pkg::REG_D] = ix[7:0];
            end
          end
          cpx_pkg::OP_INDEX_PAIR2_STORE,
          cpx_pkg::OP_INDEX_PAIR3_STORE: begin
            d.req   = 1'b1;
            d.we    = 1'b1;
            d.be    = cpx_pkg::BE_LOW_HALF;
            d.wdata = (q.ir.op == cpx_pkg::OP_INDEX_PAIR2_STORE)
                      ? {16'h0000, q.regs[cpx_pkg::REG_A], q.regs[cpx_pkg::REG_C]}
                      : {16'h0000, q.regs[cpx_pkg::REG_B], q.regs[cpx_pkg::REG_D]};
          end
          cpx_pkg::OP_ADD,
          cpx_pkg::OP_SUB: begin
            d.regs[q.ir.r] = alu_bus.res;
            if (alu_bus.carry) begin
              d.ovf = 1'b1;
            end
          end
          cpx_pkg::OP_CHAR_COMPARE: skip = alu_bus.gt ? 2'd0 : (alu_bus.eq ? 2'd1 : 2'd2);
          cpx_pkg::OP_SET_BITS,
          cpx_pkg::OP_SHIFT_LEFT,
          cpx_pkg::OP_CYCLIC_LEFT_ROTATE: d.regs[q.ir.r] = alu_bus.res;
          cpx_pkg::OP_BIT_TEST,
          cpx_pkg::OP_PARITY_TEST: skip = {1'b0, alu_bus.hit};
          cpx_pkg::OP_JUMP: begin
            jumped = 1'b1;
            d.pc   = q.ea[17:2];
          end
          cpx_pkg::OP_JUMP_AND_LINK: begin
            lw.w    = pc_next1;
            d.req   = 1'b1;
            d.we    = 1'b1;
            d.be    = cpx_pkg::BE_ALL;
            d.wdata = lw;
            jumped  = 1'b1;
            d.pc    = q.ea[17:2] + cpx_pkg::PC_STEP;
          end
          cpx_pkg::OP_HALT_INSTR: begin
            d.run = 1'b0;
            d.st  = cpx_pkg::ST_HALT;
          end
          cpx_pkg::OP_INDEX_DECREMENT,
          cpx_pkg::OP_INDEX_INCREMENT: begin
            if (q.ir.op == cpx_pkg::OP_INDEX_DECREMENT) begin
              ires = {1'b0, ix} - {1'b0, step};
              iovf = ires[16] || (wide ? ires[15:0] == 16'h0000 : ires[7:0] == 8'h00);
              if (q.ir.i && !iovf) begin
                jumped = 1'b1;
                d.pc   = q.ir.w;
              end
            end else begin
              ires = {1'b0, ix} + {1'b0, step};
              iovf = wide ? ires[16] : ires[8];
              if (wide ? ({2'b00, ires[15:0]} <= {q.ir.w, q.ir.c})
                       : ({10'h000, ires[7:0]} <= {q.ir.w, q.ir.c})) begin
                skip = {1'b0, q.ir.i && !iovf};
              end
            end
            if (q.ir.x == cpx_pkg::X_PAIR2) begin
              d.regs[cpx_pkg::REG_A] = ires[15:8];
              d.regs[cpx_pkg::REG_C] = ires[7:0];
            end else if (q.ir.x == cpx_pkg::X_PAIR3) begin
              d.regs[cpx_pkg::REG_B] = ires[15:8];
              d.regs[cpx_pkg::REG_D] = ires[7:0];
            end else if (q.ir.x != cpx_pkg::X_NONE && q.ir.x != cpx_pkg::X_DIRECT) begin
              d.regs[q.ir.x] = ires[7:0];
            end
          end
          default: d.st = cpx_pkg::ST_FETCH;
        endcase
        if (!jumped) begin
          d.pc = pc_next1 + {14'h0000, skip};
        end
      end
      default: d.st = cpx_pkg::ST_HALT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  assign mem_req_o   = q.req;
  assign mem_we_o    = q.we;
  assign mem_addr_o  = q.addr;
  assign mem_wdata_o = q.wdata;
  assign mem_be_o    = q.be;
  assign running_o   = q.run;
  assign overflow_o  = q.ovf;
  assign pc_o        = q.pc;
  assign data_regs_o = q.regs;

endmodule

`default_nettype wire

// ===== tb/cpx_mem_model.sv
// Behavioural word memory that answers each read one cycle later.
// Assumes requests are single-cycle pulses and addresses below 256.
`timescale 1ns/1ns
`default_nettype none
module cpx_mem_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  be_i,
  output var  logic        rvalid_o,
  output var  logic [31:0] rdata_o
);
  logic [31:0] mem [0:255];
  initial begin
    rvalid_o = 1'b0;
    rdata_o = 32'h0;
  end
  always @(posedge clk_i) begin
    rvalid_o <= req_i && !we_i;
    // Stale data inverted so a held bus is never trusted
    rdata_o <= (req_i && !we_i) ? mem[addr_i[7:0]] : ~rdata_o;
    for (int b = 0; b < 4; b++) begin
      if (req_i && we_i && be_i[b]) mem[addr_i[7:0]][8*b +: 8] <= wdata_i[8*b +: 8];
    end
  end
endmodule
`default_nettype wire

// ===== tb/cpx_exec_properties.sv
// Port-level checks of the character processor sequencer.
// Assumes one clock domain; bound to every cpx_exec instance.
`timescale 1ns/1ns
`default_nettype none
module cpx_exec_properties (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        start_i,
  input wire logic        ovf_clr_i,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [3:0]  mem_be_o,
  input wire logic        running_o,
  input wire logic        overflow_o,
  input wire logic [15:0] pc_o,
  input wire logic [63:0] data_regs_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence rd_s; mem_req_o && !mem_we_o; endsequence
  sequence fetch_s; mem_req_o && !mem_we_o && mem_addr_o == pc_o; endsequence
  ovf_hold_a: assert property (overflow_o && !ovf_clr_i |=> overflow_o)
    else $error("overflow memo dropped");
  ovf_set_a: assert property ($rose(overflow_o) |-> $past(running_o))
    else $error("overflow set while halted");
  ovf_clear_a: assert property ($fell(overflow_o) |-> $past(ovf_clr_i))
    else $error("overflow cleared unasked");
  halt_hold_a: assert property (!running_o && !start_i |=> !running_o)
    else $error("run without start");
  halt_quiet_a: assert property (!running_o && !$past(running_o) |->
    !mem_req_o && $stable(pc_o) && $stable(data_regs_o)) else $error("activity while halted");
  resume_fetch_a: assert property ($rose(running_o) |-> ##[1:4] fetch_s)
    else $error("restart not at pc");
  next_fetch_a: assert property (running_o && $changed(pc_o) |-> ##[0:3] fetch_s)
    else $error("no fetch at new pc");
  read_be_a: assert property (rd_s |-> mem_be_o == 4'hf)
    else $error("read without all lanes");
endmodule
bind cpx_exec cpx_exec_properties u_props (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
  .start_i(start_i), .ovf_clr_i(ovf_clr_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o), .running_o(running_o),
  .overflow_o(overflow_o), .pc_o(pc_o), .data_regs_o(data_regs_o));
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench: runs a short program held in the memory model.
// Assumes design, checker and memory model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {logic [3:0] sel; logic [7:0] adr; logic [31:0] exp;} cpx_row_t;
  logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, start_i = 1'b0, ovf_clr_i = 1'b0;
  logic        mem_rvalid_i, mem_req_o, mem_we_o, running_o, overflow_o;
  logic [15:0] mem_addr_o, pc_o;
  logic [31:0] mem_rdata_i, mem_wdata_o;
  logic [3:0]  mem_be_o;
  logic [63:0] data_regs_o;
  logic [31:0] prog [14];
  int          bad_count = 0, checks_done = 0, cycles = 0;
  cpx_row_t    rows [11];
  always #2 sys_clk_i = ~sys_clk_i;
  cpx_exec DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .start_i(start_i),
    .ovf_clr_i(ovf_clr_i), .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_be_o(mem_be_o), .running_o(running_o),
    .overflow_o(overflow_o), .pc_o(pc_o), .data_regs_o(data_regs_o));
  cpx_mem_model MEM (.clk_i(sys_clk_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .be_i(mem_be_o),
    .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
  function automatic logic [31:0] ins(logic [5:0] op, logic [2:0] r, logic [17:0] wc,
                                      logic u = 1'b0, logic [2:0] x = 3'h0);
    return {op, u, r, 1'b0, x, wc};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic run();
    @(posedge sys_clk_i) #1 start_i = 1'b1;
    @(posedge sys_clk_i) #1 start_i = 1'b0;
    repeat (900) if (running_o !== 1'b0) @(posedge sys_clk_i) #1;
    chk({31'h0, running_o}, 32'h0);
  endtask
  // Hang guard; the whole program needs about a hundred cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    prog = '{ins(cpx_pkg::OP_CHAR_LOAD, 3'h0, 18'h5, 1'b0, 3'h1),
      ins(cpx_pkg::OP_CHAR_LOAD, 3'h1, 18'hf0, 1'b0, 3'h1),
      ins(cpx_pkg::OP_ADD, 3'h0, 18'hfe, 1'b0, 3'h1), ins(cpx_pkg::OP_SUB, 3'h1, 18'h10, 1'b0, 3'h1),
      ins(cpx_pkg::OP_HIGH_GROUP_LOAD, 3'h0, 18'h100), ins(cpx_pkg::OP_MASKED_CHAR_LOAD, 3'h1, 18'h104),
      ins(cpx_pkg::OP_SET_BITS, 3'h2, 18'h81, 1'b1), ins(cpx_pkg::OP_CYCLIC_LEFT_ROTATE, 3'h2, 18'h3),
      ins(cpx_pkg::OP_SHIFT_LEFT, 3'h5, 18'h4), ins(cpx_pkg::OP_LOW_GROUP_STORE, 3'h0, 18'h108),
      ins(cpx_pkg::OP_CHAR_COMPARE, 3'h0, 18'h3, 1'b0, 3'h1), ins(cpx_pkg::OP_HALT_INSTR, 3'h0, 18'h0),
      ins(cpx_pkg::OP_MASKED_CHAR_STORE, 3'h6, 18'h10f), ins(cpx_pkg::OP_JUMP_AND_LINK, 3'h0, 18'h110)};
    foreach (prog[k]) MEM.mem[k] = prog[k];
    MEM.mem[8'h40] = 32'h0f112233;
    MEM.mem[8'h41] = 32'haa000000;
    MEM.mem[8'h42] = 32'hffffffff;
    MEM.mem[8'h43] = 32'h5a5a5af0;
    MEM.mem[8'h44] = 32'hffffffff;
    MEM.mem[8'h45] = prog[11];
    MEM.mem[8'h46] = ins(cpx_pkg::OP_PARITY_TEST, 3'h0, 18'h3);
    MEM.mem[8'h48] = prog[11];
    rows = '{'{4'h0, 8'h0, 32'h03}, '{4'h1, 8'h0, 32'hea}, '{4'h2, 8'h0, 32'h0c},
      '{4'h3, 8'h0, 32'h00}, '{4'h4, 8'h0, 32'h0f}, '{4'h5, 8'h0, 32'h10},
      '{4'h6, 8'h0, 32'h22}, '{4'h7, 8'h0, 32'h33}, '{4'h8, 8'h42, 32'h03ea0c00},
      '{4'h8, 8'h43, 32'h5a5a5af2}, '{4'h8, 8'h44, 32'hfffc003b}};
    repeat (2) @(posedge sys_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (3) @(posedge sys_clk_i);
    run();
    foreach (rows[k]) chk(rows[k].sel[3] ? MEM.mem[rows[k].adr] :
      {24'h0, data_regs_o[8*rows[k].sel[2:0] +: 8]}, rows[k].exp);
    chk({31'h0, overflow_o}, 32'h1);
    chk({16'h0, pc_o}, 32'h46);
    $display("program test done");
    @(posedge sys_clk_i) #1 ovf_clr_i = 1'b1;
    @(posedge sys_clk_i) #1 ovf_clr_i = 1'b0;
    chk({31'h0, overflow_o}, 32'h0);
    run();
    chk({16'h0, pc_o}, 32'h49);
    $display("restart test done");
    rst_b_i = 1'b0;
    @(posedge sys_clk_i) #1;
    chk(data_regs_o[31:0] | {16'h0, pc_o}, 32'h0);
    $display("reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
